// *** design/accel_output_status_regs.sv ***
// Read-only output, status, mode and interrupt origin register bank.
`timescale 1ns/10ps
module accel_output_status_regs (
  input wire logic clk,
  input wire logic rst,
  input wire accel_regs_pkg::rd_req_t rd_req,
  output logic [7:0] rd_data,
  output logic rd_valid,
  input wire accel_regs_pkg::sample_t sample_in,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic fast_read_en,
  input wire logic drdy_int_en,
  input wire logic [1:0] mode_in,
  input wire logic sleep_wake_event,
  input wire logic orient_event,
  input wire logic fall_event,
  input wire logic orient_src_read,
  input wire logic fall_src_read
);
  localparam int AX = accel_regs_pkg::AXES;
  localparam int SW = accel_regs_pkg::SAMPLE_W;
  localparam int HS = accel_regs_pkg::HI_SHIFT;

  accel_regs_pkg::sample_t fifo_data;
  logic fifo_valid, pop;

  // Samples wait here while a host burst is open, so a burst sees one stable snapshot.
  sample_fifo #(
    .WIDTH($bits(accel_regs_pkg::sample_t)),
    .DEPTH(accel_regs_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_data(sample_in),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(pop)
  );

  logic burst_reg, burst_next;
  logic [7:0] ptr_reg, ptr_next;
  logic [7:0] lo_ok_reg, lo_ok_next;
  logic [HS-1:0] lo_hold_reg, lo_hold_next;
  logic [7:0] rd_data_next;
  logic [7:0] status_byte, irq_byte, mux_byte;
  logic [SW-1:0] axis_reg [AX];
  logic [SW-1:0] axis_next [AX];
  logic [AX-1:0] axis_new_reg, axis_new_next, hi_seen_reg, hi_seen_next;
  logic [AX-1:0] hi_sel, new_axis;
  logic new_any, all_read, new_all_reg, new_all_next, ovr_reg, ovr_next;
  accel_regs_pkg::op_mode_t mode_reg, mode_next;
  logic sleep_flag_reg, sleep_flag_next, orient_flag_reg, orient_flag_next;
  logic fall_flag_reg, fall_flag_next, drdy_flag_reg, drdy_flag_next;
  logic sleep_prev_reg, orient_prev_reg, fall_prev_reg, cond_prev_reg;
  logic drdy_cond, drdy_rise, mode_read;

  // Draining pauses during an open burst, which back-pressures the sample source.
  assign pop = fifo_valid && !burst_reg && !rd_req.start;

  // Per-axis data, new-sample flags and high-read tracking.
  for (genvar i = 0; i < AX; i++) begin : g_axis
    always_comb begin
      hi_sel[i] = rd_req.strobe && !rd_req.start && ptr_reg == accel_regs_pkg::HI_ADDR[i];
      new_axis[i] = pop && fifo_data.axis_valid[i];
      axis_new_next[i] = new_axis[i] || (axis_new_reg[i] && !hi_sel[i]);
      hi_seen_next[i] = (new_any || all_read) ? 1'b0 : (hi_seen_reg[i] || hi_sel[i]);
    end
  end

  always_comb begin
    new_any = |new_axis;
    all_read = &(hi_seen_reg | hi_sel);
    axis_next[0] = new_axis[0] ? fifo_data.x : axis_reg[0];
    axis_next[1] = new_axis[1] ? fifo_data.y : axis_reg[1];
    axis_next[2] = new_axis[2] ? fifo_data.z : axis_reg[2];
    new_all_next = new_any || (new_all_reg && !all_read);
    ovr_next = (|(new_axis & axis_new_reg)) || (ovr_reg && !all_read);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int k = 0; k < AX; k++) begin
        axis_reg[k] <= accel_regs_pkg::SAMPLE_RESET;
      end
      axis_new_reg <= '0;
      hi_seen_reg <= '0;
      new_all_reg <= 1'b0;
      ovr_reg <= 1'b0;
    end else begin
      for (int k = 0; k < AX; k++) begin
        axis_reg[k] <= axis_next[k];
      end
      axis_new_reg <= axis_new_next;
      hi_seen_reg <= hi_seen_next;
      new_all_reg <= new_all_next;
      ovr_reg <= ovr_next;
    end
  end

  // Mode and interrupt origin flags; a set in the same cycle as its clear wins.
  always_comb begin
    mode_read = rd_req.strobe && !rd_req.start && ptr_reg == accel_regs_pkg::ADDR_MODE;
    if (mode_in == accel_regs_pkg::MODE_CODE_RESERVED) begin
      mode_next = mode_reg;
    end else begin
      mode_next = accel_regs_pkg::op_mode_t'(mode_in);
    end
    drdy_cond = (ovr_reg || new_all_reg) && drdy_int_en;
    drdy_rise = drdy_cond && !cond_prev_reg;
    sleep_flag_next = (sleep_wake_event && !sleep_prev_reg)
      || (sleep_flag_reg && !mode_read);
    orient_flag_next = (orient_event && !orient_prev_reg)
      || (orient_flag_reg && !orient_src_read);
    fall_flag_next = (fall_event && !fall_prev_reg)
      || (fall_flag_reg && !fall_src_read);
    drdy_flag_next = drdy_rise || (drdy_flag_reg && !all_read);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg <= accel_regs_pkg::MODE_STANDBY;
      sleep_flag_reg <= 1'b0;
      orient_flag_reg <= 1'b0;
      fall_flag_reg <= 1'b0;
      drdy_flag_reg <= 1'b0;
      sleep_prev_reg <= 1'b0;
      orient_prev_reg <= 1'b0;
      fall_prev_reg <= 1'b0;
      cond_prev_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      sleep_flag_reg <= sleep_flag_next;
      orient_flag_reg <= orient_flag_next;
      fall_flag_reg <= fall_flag_next;
      drdy_flag_reg <= drdy_flag_next;
      sleep_prev_reg <= sleep_wake_event;
      orient_prev_reg <= orient_event;
      fall_prev_reg <= fall_event;
      cond_prev_reg <= drdy_cond;
    end
  end

  // Read path: address pointer, low-byte pairing and the read data mux.
  always_comb begin
    status_byte = accel_regs_pkg::BYTE_ZERO;
    status_byte[accel_regs_pkg::STAT_OVR_BIT] = ovr_reg;
    status_byte[accel_regs_pkg::STAT_NEW_BIT] = new_all_reg;
    for (int k = 0; k < AX; k++) begin
      status_byte[accel_regs_pkg::STAT_X_BIT + k] = axis_new_reg[k];
    end
    irq_byte = accel_regs_pkg::BYTE_ZERO;
    irq_byte[accel_regs_pkg::IRQ_SLEEP_BIT] = sleep_flag_reg;
    irq_byte[accel_regs_pkg::IRQ_ORIENT_BIT] = orient_flag_reg;
    irq_byte[accel_regs_pkg::IRQ_FALL_BIT] = fall_flag_reg;
    irq_byte[accel_regs_pkg::IRQ_DRDY_BIT] = drdy_flag_reg;
    mux_byte = accel_regs_pkg::BYTE_ZERO;
    if (ptr_reg == accel_regs_pkg::ADDR_STATUS) begin
      mux_byte = status_byte;
    end else if (ptr_reg == accel_regs_pkg::ADDR_MODE) begin
      mux_byte = {accel_regs_pkg::MODE_PAD, mode_reg};
    end else if (ptr_reg == accel_regs_pkg::ADDR_IRQ) begin
      mux_byte = irq_byte;
    end
    lo_hold_next = lo_hold_reg;
    lo_ok_next = lo_ok_reg;
    for (int k = 0; k < AX; k++) begin
      if (ptr_reg == accel_regs_pkg::HI_ADDR[k]) begin
        mux_byte = axis_reg[k][SW-1:HS];
      end
      if (ptr_reg == accel_regs_pkg::LO_ADDR[k] && lo_ok_reg == ptr_reg) begin
        mux_byte = {lo_hold_reg, accel_regs_pkg::LO_PAD};
      end
    end
    if (rd_req.strobe && !rd_req.start) begin
      lo_ok_next = accel_regs_pkg::ADDR_NONE;
      for (int k = 0; k < AX; k++) begin
        if (hi_sel[k]) begin
          lo_hold_next = axis_reg[k][HS-1:0];
          lo_ok_next = accel_regs_pkg::LO_ADDR[k];
        end
      end
    end
    rd_data_next = (rd_req.strobe && !rd_req.start) ? mux_byte : rd_data;
    burst_next = burst_reg;
    ptr_next = ptr_reg;
    if (rd_req.start) begin
      burst_next = 1'b1;
      ptr_next = rd_req.addr;
      lo_ok_next = accel_regs_pkg::ADDR_NONE;
    end else begin
      if (rd_req.stop) begin
        burst_next = 1'b0;
      end
      if (rd_req.strobe) begin
        if (fast_read_en && hi_sel != '0) begin
          ptr_next = ptr_reg + accel_regs_pkg::ADDR_FAST_STEP;
        end else begin
          ptr_next = ptr_reg + accel_regs_pkg::ADDR_STEP;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      burst_reg <= 1'b0;
      ptr_reg <= accel_regs_pkg::ADDR_STATUS;
      lo_ok_reg <= accel_regs_pkg::ADDR_NONE;
      lo_hold_reg <= '0;
      rd_data <= accel_regs_pkg::BYTE_ZERO;
      rd_valid <= 1'b0;
    end else begin
      burst_reg <= burst_next;
      ptr_reg <= ptr_next;
      lo_ok_reg <= lo_ok_next;
      lo_hold_reg <= lo_hold_next;
      rd_data <= rd_data_next;
      rd_valid <= rd_req.strobe && !rd_req.start;
    end
  end

  logic rd_take;
  logic [HS-1:0] x_low_bits;
  assign rd_take = rd_req.strobe && !rd_req.start;
  assign x_low_bits = axis_reg[0][HS-1:0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_NEW_ALL_SET: assert property (new_any |=> new_all_reg && status_byte[3])
    else $error("Combined new-sample bit not set after a sample.");
  AST_NEW_ALL_CLR: assert property (all_read && !new_any |=> !new_all_reg)
    else $error("Combined new-sample bit not cleared after all high reads.");
  AST_AXIS_CLR: assert property (hi_sel[1] && !new_axis[1] |=> !axis_new_reg[1])
    else $error("Axis flag not cleared by its high read.");
  AST_LO_PAD: assert property (rd_take && ptr_reg == accel_regs_pkg::ADDR_Z_LO
    |=> rd_data[5:0] == '0)
    else $error("Low byte padding bits not zero.");
  AST_AXIS_SET: assert property (new_axis[2] |=> axis_new_reg[2])
    else $error("Axis flag not set by its sample.");

  AST_BURST_STEP: assert property (rd_take && !fast_read_en
    && ptr_reg == accel_regs_pkg::ADDR_X_HI |=> ptr_reg == accel_regs_pkg::ADDR_X_LO)
    else $error("Burst pointer did not step through the high byte.");
  AST_FAST_SKIP: assert property (rd_take && fast_read_en
    && ptr_reg == accel_regs_pkg::ADDR_X_HI |=> ptr_reg == accel_regs_pkg::ADDR_Y_HI)
    else $error("Fast read did not skip the low byte.");
  AST_LO_RANDOM: assert property (rd_take && ptr_reg == accel_regs_pkg::ADDR_Y_LO
    && lo_ok_reg != accel_regs_pkg::ADDR_Y_LO |=> rd_data == '0)
    else $error("Low byte readable without its high byte.");
  AST_COHERENT: assert property (rd_take && ptr_reg == accel_regs_pkg::ADDR_X_HI
    ##2 rd_take && ptr_reg == accel_regs_pkg::ADDR_X_LO
    |=> rd_data[7:6] == $past(x_low_bits, 3))
    else $error("Low byte not from the same sample as its high byte.");

  AST_MODE_LEGAL: assert property (mode_in != accel_regs_pkg::MODE_CODE_RESERVED
    |=> mode_reg == $past(mode_in))
    else $error("Mode field does not follow the mode input.");

  AST_MODE_NOT_RES: assert property (mode_reg != accel_regs_pkg::MODE_CODE_RESERVED)
    else $error("Reserved mode code shown.");

  AST_MODE_PAD: assert property (rd_take && ptr_reg == accel_regs_pkg::ADDR_MODE
    |=> rd_data[7:2] == '0)
    else $error("Reserved mode bits not zero.");

  AST_STAT_PAD: assert property (rd_take && ptr_reg == accel_regs_pkg::ADDR_STATUS
    |=> rd_data[6:4] == '0)
    else $error("Reserved status bits not zero.");

  AST_FALL_SET: assert property (fall_event && !fall_prev_reg |=> fall_flag_reg)
    else $error("Fall/motion flag not set by its event.");
  AST_SRC_HOLD: assert property ($rose(orient_event)
    |=> orient_flag_reg [*2] or (orient_flag_reg ##1 $past(orient_src_read)))
    else $error("Orientation flag not held after its event.");
  AST_DRDY_STATUS: assert property (drdy_flag_reg && rd_take
    && ptr_reg == accel_regs_pkg::ADDR_STATUS && !all_read |=> drdy_flag_reg)
    else $error("Data-ready flag cleared by a status read.");
  AST_IRQ_RESERVED: assert property (rd_take && ptr_reg == accel_regs_pkg::ADDR_IRQ
    |=> rd_data[6:5] == '0 && rd_data[3] == 1'b0 && rd_data[1] == 1'b0)
    else $error("Reserved origin bits not zero.");
  AST_DRDY_CLR: assert property (all_read && !drdy_rise |=> !drdy_flag_reg)
    else $error("Data-ready flag not cleared after all high reads.");

  AST_OVR_SET: assert property (|(new_axis & axis_new_reg) |=> ovr_reg)
    else $error("Overrun bit not set on overwritten sample.");

  AST_OVR_CLR: assert property (all_read && !(|(new_axis & axis_new_reg))
    |=> !ovr_reg)
    else $error("Overrun bit not cleared after all high reads.");
  AST_DRDY_SET: assert property (drdy_rise |=> drdy_flag_reg)
    else $error("Data-ready origin flag not set.");
  AST_SLEEP_CLR: assert property (mode_read && !(sleep_wake_event && !sleep_prev_reg)
    |=> !sleep_flag_reg)
    else $error("Sleep/wake flag not cleared by mode read.");

  COV_FULL_BURST: cover property (rd_take && ptr_reg == accel_regs_pkg::ADDR_STATUS
    ##1 rd_take [*6]);
  COV_FAST_BURST: cover property (fast_read_en && rd_take [*4]);
  COV_FIFO_FULL: cover property (sample_valid && !sample_ready);
  COV_DRDY: cover property (drdy_flag_reg ##1 !drdy_flag_reg);
endmodule : accel_output_status_regs

// *** design/accel_regs_pkg.sv ***
// Constants, types and field layout shared by the accelerometer output and status bank.
// Overview of operation
// - The combined new-sample status bit 3 is set whenever any enabled axis delivers a sample.
// - The combined new-sample bit clears once the high bytes of all three axes have been read.
// - Each axis flag (Z bit 2, Y bit 1, X bit 0) sets on its sample and clears on its high read.
// - Samples sit at 0x01 to 0x06 as X, Y, Z pairs, high byte bits 9..2, low byte bits 1..0 on top.
// - A burst read walks the address up from the status byte through all six data bytes.
// - With fast read set, auto-increment skips every low byte, so a burst takes four bytes.
// - A low byte reads only directly after its own high byte; otherwise it reads zero.
// - A high read followed by its low read returns both parts of the same sample.
// - The two-bit mode field shows standby 00 after reset, wake 01 and sleep 10.
// - Each interrupt origin flag sets on a rising event and stays until its own clear; orientation and fall/motion clear on their source reads.
// - The data-ready origin flag survives status reads and clears when all high bytes are read.
// - Origin flags sit at bit 7 sleep/wake, 4 orientation, 2 fall/motion, 0 data ready.
// - The combined overrun bit sets when a sample replaces an unread one, clears on all reads.
// - The data-ready origin flag rises when overrun or new-sample is set and it is enabled.
// - The sleep/wake origin flag clears when the mode register is read.
package accel_regs_pkg;
  localparam int SAMPLE_W = 10;
  localparam int AXES = 3;
  localparam int FIFO_DEPTH = 8;
  localparam int HI_SHIFT = 2;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_X_HI = 8'h01;
  localparam logic [7:0] ADDR_X_LO = 8'h02;
  localparam logic [7:0] ADDR_Y_HI = 8'h03;
  localparam logic [7:0] ADDR_Y_LO = 8'h04;
  localparam logic [7:0] ADDR_Z_HI = 8'h05;
  localparam logic [7:0] ADDR_Z_LO = 8'h06;
  localparam logic [7:0] ADDR_MODE = 8'h0B;
  localparam logic [7:0] ADDR_IRQ = 8'h0C;
  localparam logic [7:0] ADDR_NONE = 8'hFF;
  localparam logic [7:0] ADDR_STEP = 8'h01;
  localparam logic [7:0] ADDR_FAST_STEP = 8'h02;
  localparam logic [AXES-1:0][7:0] HI_ADDR = {ADDR_Z_HI, ADDR_Y_HI, ADDR_X_HI};
  localparam logic [AXES-1:0][7:0] LO_ADDR = {ADDR_Z_LO, ADDR_Y_LO, ADDR_X_LO};
  localparam int STAT_OVR_BIT = 7;
  localparam int STAT_NEW_BIT = 3;
  localparam int STAT_X_BIT = 0;
  localparam int IRQ_SLEEP_BIT = 7;
  localparam int IRQ_ORIENT_BIT = 4;
  localparam int IRQ_FALL_BIT = 2;
  localparam int IRQ_DRDY_BIT = 0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [5:0] LO_PAD = 6'h00;
  localparam logic [5:0] MODE_PAD = 6'h00;
  localparam logic [1:0] MODE_CODE_RESERVED = 2'h3;
  localparam logic [SAMPLE_W-1:0] SAMPLE_RESET = 10'h000;

  typedef enum logic [1:0] {
    MODE_STANDBY = 2'b00,
    MODE_WAKE = 2'b01,
    MODE_SLEEP = 2'b10
  } op_mode_t;

  typedef struct packed {
    logic [AXES-1:0] axis_valid;
    logic [SAMPLE_W-1:0] z;
    logic [SAMPLE_W-1:0] y;
    logic [SAMPLE_W-1:0] x;
  } sample_t;

  typedef struct packed {
    logic start;
    logic [7:0] addr;
    logic strobe;
    logic stop;
  } rd_req_t;
endpackage : accel_regs_pkg

// *** design/sample_fifo.sv ***
// Parameterised valid/ready FIFO that buffers incoming samples.
`timescale 1ns/10ps
module sample_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_CNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST = (PW)'(DEPTH - 1);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [PW:0] cnt_reg, cnt_next;
  logic push, pop;

  // Full and empty come straight from the occupancy count.
  always_comb begin
    in_ready = cnt_reg != DEPTH_CNT;
    out_valid = cnt_reg != '0;
    out_data = mem_reg[rd_reg];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_next = push ? ((wr_reg == LAST) ? '0 : wr_reg + 1'b1) : wr_reg;
    rd_next = pop ? ((rd_reg == LAST) ? '0 : rd_reg + 1'b1) : rd_reg;
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage has no reset; only locations written are ever read.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end
endmodule : sample_fifo

// *** tb/host_reader.sv ***
// Host model that drives the register read port in bursts.
`timescale 1ns/10ps
module host_reader (
  input wire logic clk,
  output accel_regs_pkg::rd_req_t rd_req,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  initial begin
    rd_req = '0;
  end

  // Opens a burst; the address lines show the inverse once the start is over.
  task automatic open_burst(input logic [7:0] addr);
    @(negedge clk);
    rd_req <= '{start: 1'b1, addr: addr, strobe: 1'b0, stop: 1'b0};
    @(negedge clk);
    rd_req <= '{start: 1'b0, addr: ~addr, strobe: 1'b0, stop: 1'b0};
  endtask : open_burst

  // Reads one byte; a missing answer comes back as unknown.
  task automatic read_byte(output logic [7:0] data);
    @(negedge clk);
    rd_req.strobe <= 1'b1;
    @(negedge clk);
    rd_req.strobe <= 1'b0;
    data = (rd_valid === 1'b1) ? rd_data : 8'hXX;
  endtask : read_byte

  task automatic stop_burst();
    @(negedge clk);
    rd_req.stop <= 1'b1;
    @(negedge clk);
    rd_req.stop <= 1'b0;
  endtask : stop_burst
endmodule : host_reader

// *** tb/tb_accel_output_status_regs.sv ***
// Self-checking bench for the output and status register bank.
`timescale 1ns/10ps
module tb_accel_output_status_regs;
  typedef struct packed {
    logic [2:0] av;
    logic [9:0] x;
    logic [9:0] y;
    logic [9:0] z;
    logic fast;
    logic [0:6][7:0] exp;
  } row_t;
  logic clk;
  logic rst;
  accel_regs_pkg::rd_req_t rd_req;
  logic [7:0] rd_data;
  logic rd_valid;
  accel_regs_pkg::sample_t sample_in;
  logic sample_valid;
  logic sample_ready;
  logic fast_read_en;
  logic drdy_int_en;
  logic [1:0] mode_in;
  logic sleep_wake_event;
  logic orient_event;
  logic fall_event;
  logic orient_src_read;
  logic fall_src_read;
  int err_total = 0;
  int checked = 0;
  row_t rows [3] = '{
    '{3'h7, 10'h3FF, 10'h155, 10'h2A2, 1'b0, {8'h0F, 8'hFF, 8'hC0, 8'h55, 8'h40, 8'hA8, 8'h80}},
    '{3'h7, 10'h001, 10'h202, 10'h0FE, 1'b1, {8'h0F, 8'h00, 8'h80, 8'h3F, 8'h00, 8'h00, 8'h00}},
    '{3'h1, 10'h2C7, 10'h000, 10'h000, 1'b0, {8'h09, 8'hB1, 8'hC0, 8'h80, 8'h80, 8'h3F, 8'h80}}
  };
  logic [0:6][7:0] fill_exp = {8'h8F, 8'h41, 8'hC0, 8'h00, 8'h00, 8'h00, 8'h00};

  accel_output_status_regs accel_output_status_regs_i (
    .clk(clk), .rst(rst), .rd_req(rd_req), .rd_data(rd_data), .rd_valid(rd_valid),
    .sample_in(sample_in), .sample_valid(sample_valid), .sample_ready(sample_ready),
    .fast_read_en(fast_read_en), .drdy_int_en(drdy_int_en), .mode_in(mode_in),
    .sleep_wake_event(sleep_wake_event), .orient_event(orient_event), .fall_event(fall_event),
    .orient_src_read(orient_src_read), .fall_src_read(fall_src_read)
  );
  host_reader host_reader_i (.clk(clk), .rd_req(rd_req), .rd_data(rd_data), .rd_valid(rd_valid));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic report_and_stop();
    if (err_total == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #800000;
    err_total++;
    report_and_stop();
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic push(input logic [2:0] av, input logic [9:0] x, y, z);
    int n = 0;
    @(negedge clk);
    sample_in = '{axis_valid: av, z: z, y: y, x: x};
    sample_valid = 1'b1;
    while (sample_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    sample_valid = 1'b0;
    sample_in = ~sample_in;
  endtask : push

  task automatic burst(input logic [7:0] a, input int n, output logic [0:6][7:0] b);
    b = '0;
    host_reader_i.open_burst(a);
    for (int k = 0; k < n; k++) begin
      host_reader_i.read_byte(b[k]);
    end
    host_reader_i.stop_burst();
  endtask : burst

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [0:6][7:0] b;
    burst(a, 1, b);
    check(b[0], e);
  endtask : rdchk

  initial begin
    logic [0:6][7:0] b;
    logic [7:0] d;
    sample_in = '0;
    sample_valid = 1'b0;
    fast_read_en = 1'b0;
    drdy_int_en = 1'b0;
    mode_in = 2'h0;
    sleep_wake_event = 1'b0;
    orient_event = 1'b0;
    fall_event = 1'b0;
    orient_src_read = 1'b0;
    fall_src_read = 1'b0;
    rst = 1'b1;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    foreach (rows[i]) begin
      fast_read_en = rows[i].fast;
      push(rows[i].av, rows[i].x, rows[i].y, rows[i].z);
      repeat (4) @(negedge clk);
      burst(8'h00, rows[i].fast ? 4 : 7, b);
      for (int k = 0; k < (rows[i].fast ? 4 : 7); k++) begin
        check(b[k], rows[i].exp[k]);
      end
    end
    fast_read_en = 1'b0;
    rdchk(8'h04, 8'h00);
    host_reader_i.open_burst(8'h01);
    host_reader_i.read_byte(d);
    check(d, 8'hB1);
    push(3'h7, 10'h000, 10'h000, 10'h000);
    host_reader_i.read_byte(d);
    check(d, 8'hC0);
    host_reader_i.stop_burst();
    repeat (4) @(negedge clk);
    host_reader_i.open_burst(8'h0B);
    for (int i = 0; i < 8; i++) begin
      push(3'h7, 10'h100 + 10'(i), 10'h000, 10'h000);
    end
    check({7'h00, sample_ready}, 8'h00);
    host_reader_i.stop_burst();
    repeat (20) @(negedge clk);
    burst(8'h00, 7, b);
    for (int k = 0; k < 7; k++) begin
      check(b[k], fill_exp[k]);
    end
    rdchk(8'h00, 8'h00);
    for (int m = 1; m < 4; m++) begin
      mode_in = 2'(m);
      repeat (2) @(negedge clk);
      rdchk(8'h0B, (m == 3) ? 8'h02 : 8'(m));
    end
    sleep_wake_event = 1'b1;
    repeat (2) @(negedge clk);
    rdchk(8'h0C, 8'h80);
    rdchk(8'h0C, 8'h80);
    rdchk(8'h0B, 8'h02);
    rdchk(8'h0C, 8'h00);
    orient_event = 1'b1;
    fall_event = 1'b1;
    repeat (2) @(negedge clk);
    rdchk(8'h0C, 8'h14);
    @(negedge clk);
    orient_src_read = 1'b1;
    @(negedge clk);
    orient_src_read = 1'b0;
    rdchk(8'h0C, 8'h04);
    fall_src_read = 1'b1;
    @(negedge clk);
    fall_src_read = 1'b0;
    rdchk(8'h0C, 8'h00);
    drdy_int_en = 1'b1;
    push(3'h7, 10'h000, 10'h000, 10'h000);
    repeat (4) @(negedge clk);
    rdchk(8'h0C, 8'h01);
    rdchk(8'h00, 8'h0F);
    rdchk(8'h0C, 8'h01);
    rdchk(8'h01, 8'h00);
    rdchk(8'h00, 8'h0E);
    rdchk(8'h03, 8'h00);
    rdchk(8'h0C, 8'h01);
    rdchk(8'h05, 8'h00);
    rdchk(8'h0C, 8'h00);
    rdchk(8'h00, 8'h00);
    push(3'h7, 10'h3FF, 10'h3FF, 10'h3FF);
    sleep_wake_event = 1'b0;
    orient_event = 1'b0;
    fall_event = 1'b0;
    mode_in = 2'h0;
    repeat (3) @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    check(rd_data, 8'h00);
    check({7'h00, sample_ready}, 8'h01);
    rdchk(8'h00, 8'h00);
    rdchk(8'h0B, 8'h00);
    rdchk(8'h0C, 8'h00);
    rdchk(8'h01, 8'h00);
    rdchk(8'h0D, 8'h00);
    report_and_stop();
  end
endmodule : tb_accel_output_status_regs
